// File: src/cycle_divider.sv
// module: system clock divider producing one tick per instruction clock
`timescale 1ns/1ns
module cycle_divider
   import cycle_timing_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   cycle_tick_if.divider    div
);
   div_state_t st;
   div_state_t next_st;

   always_comb
   begin
      next_st = st;
      // tick once every ratio oscillator periods
      next_st.tick = (st.count >= DIV_W'(div.ratio - 2'h1));
      if (next_st.tick)
      begin
         next_st.count = '0;
      end
      else
      begin
         next_st.count = DIV_W'(st.count + 2'h1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st <= DIV_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign div.tick = st.tick;
endmodule

// File: src/cycle_tick_if.sv
// interface: divided-clock ratio and tick between sequencer and divider
`timescale 1ns/1ns
interface cycle_tick_if #(parameter int DIV_W = 2);
   logic [DIV_W-1:0] ratio;
   logic             tick;

   modport divider (input ratio, output tick);
   modport core    (output ratio, input tick);
endinterface

// File: src/cycle_timing_pkg.sv
// package: constants and types for the instruction cycle sequencer
package cycle_timing_pkg;

   localparam int         DIV_W              = 2;
   localparam int         CNT_W              = 6;
   localparam int         LEN_W              = 3;

   // divided-clock ratios per mode
   localparam logic [1:0] FAST_DIV_RATIO     = 2'h1;
   localparam logic [1:0] COMPAT_DIV_RATIO   = 2'h2;

   // compatibility: one legacy machine cycle in divided clocks
   localparam logic [5:0] MACHINE_CYCLE_CLKS = 6'h6;

   // fast-mode fixed counts, plus the compatibility-mode prefixed long count
   localparam logic [5:0] FAST_RETURN        = 6'h4;
   localparam logic [5:0] FAST_CODE_READ     = 6'h3;
   localparam logic [5:0] FAST_EXT_MOVE      = 6'h4;
   localparam logic [5:0] FAST_EXT_MOVE_ALT  = 6'h5;
   localparam logic [5:0] FAST_EXT_MOVE_RI   = 6'h2;
   localparam logic [5:0] FAST_MULTIPLY      = 6'h2;
   localparam logic [5:0] FAST_DIVIDE        = 6'h4;
   localparam logic [5:0] FAST_MULT_ACC      = 6'h9;
   localparam logic [5:0] FAST_PTR_INC       = 6'h2;
   localparam logic [5:0] FAST_PTR_INC_ALT   = 6'h3;
   localparam logic [5:0] FAST_PTR_LOAD_ALT  = 6'h4;
   localparam logic [5:0] FAST_CODE_READ_ALT = 6'h4;
   localparam logic [5:0] FAST_INDIRECT      = 6'h2;
   localparam logic [5:0] FAST_PREFIX_OTHER  = 6'h2;
   localparam logic [5:0] COMPAT_PREFIX_LONG = 6'h12;

   // alternate-pointer prefix byte
   localparam logic [7:0] PREFIX_OPCODE      = 8'ha5;

   typedef enum logic [1:0] {ST_START, ST_FETCH, ST_EXEC} seq_state_t;

   typedef struct packed {
      seq_state_t        state;
      logic              fast;
      logic              prefixed;
      logic [7:0]        opcode;
      logic [15:0]       operands;
      logic [LEN_W-1:0]  bytes_need;
      logic [LEN_W-1:0]  bytes_got;
      logic [CNT_W-1:0]  cycles;
      logic [CNT_W-1:0]  elapsed;
      logic              code_req;
      logic              instr_done;
      logic              cycle_tick;
      logic [DIV_W-1:0]  div_ratio;
   } core_state_t;

   localparam core_state_t CORE_RESET = '{state: ST_START, div_ratio: COMPAT_DIV_RATIO,
                                          default: '0};

   typedef struct packed {
      logic [DIV_W-1:0] count;
      logic             tick;
   } div_state_t;

   localparam div_state_t DIV_RESET = '{default: '0};

endpackage

// File: src/instruction_cycle_timing.sv
// module: instruction fetch pacing and per-opcode cycle count sequencer
// How it works
// - every legacy opcode keeps its encoding, length and meaning
// - compatibility mode: legacy machine cycles times six divided clocks
// - modes differ only in cycle count and divider ratio, never in decode
// - fast mode counts stay within one to five cycles, except prefixed 0xa4 at nine
// - cycles are counted in divider ticks, not oscillator periods
// - fast mode divider ratio defaults to one
// - compatibility mode divider ratio defaults to two
// - fast mode: plain instructions take one cycle per byte
// - fast mode: single-byte register-indirect forms take two cycles, except 0xf6/0xf7 at one
// - fast mode fixed counts for return, code read, moves, multiply, divide
// - arithmetic groups keep legacy opcodes, six cycles in compatibility
`timescale 1ns/1ns
module instruction_cycle_timing
   import cycle_timing_pkg::*;
(
   input  wire logic                             clk,
   input  wire logic                             reset,
   input  wire logic                             fast_mode,
   input  wire logic                             code_valid,
   input  wire logic [7:0]                       code_byte,
   output logic                                  code_req,
   output logic                                  cycle_tick,
   output logic [cycle_timing_pkg::DIV_W-1:0]    div_ratio,
   output logic                                  mode_fast,
   output logic                                  instr_done,
   output logic [7:0]                            instr_opcode,
   output logic                                  instr_prefixed,
   output logic [15:0]                           instr_operands,
   output logic [cycle_timing_pkg::LEN_W-1:0]    instr_bytes,
   output logic [cycle_timing_pkg::CNT_W-1:0]    instr_cycles
);
   core_state_t st;
   core_state_t next_st;

   cycle_tick_if #(.DIV_W(DIV_W)) div ();

   cycle_divider u_divider (
      .clk   (clk),
      .reset (reset),
      .div   (div.divider)
   );

   // legacy instruction length in bytes
   function automatic logic [LEN_W-1:0] op_bytes(input logic [7:0] op);
      logic [LEN_W-1:0] n;
      n = 3'h1;
      casez (op)
         8'h?1:
            n = 3'h2;
         8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63,
         8'h75, 8'h85, 8'h90, 8'hb4, 8'hb5, 8'hd5, 8'b1011_011?, 8'b1011_1???:
            n = 3'h3;
         8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h05, 8'h15, 8'h24,
         8'h25, 8'h34, 8'h35, 8'h42, 8'h44, 8'h45, 8'h52, 8'h54,
         8'h55, 8'h62, 8'h64, 8'h65, 8'h72, 8'h74, 8'h76, 8'h77,
         8'h82, 8'h86, 8'h87, 8'h92, 8'h94, 8'h95, 8'ha0, 8'ha2,
         8'ha6, 8'ha7, 8'hb0, 8'hb2, 8'hc0, 8'hc2, 8'hc5, 8'hd0,
         8'hd2, 8'he5, 8'hf5, 8'b0111_1???, 8'b1000_1???,
         8'b1010_1???, 8'b1101_1???:
            n = 3'h2;
         default:
            n = 3'h1;
      endcase
      return n;
   endfunction

   // legacy machine cycles per instruction
   function automatic logic [2:0] machine_cycles(input logic [7:0] op);
      logic [2:0] m;
      m = 3'h1;
      casez (op)
         8'ha4, 8'h84:
            m = 3'h4;
         8'h?1, 8'h02, 8'h12, 8'h22, 8'h32, 8'h10, 8'h20, 8'h30,
         8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h73, 8'h83, 8'h93,
         8'h43, 8'h53, 8'h63, 8'h72, 8'h82, 8'ha0, 8'hb0, 8'h92,
         8'h85, 8'h86, 8'h87, 8'ha6, 8'ha7, 8'h75, 8'h90, 8'ha3,
         8'hc0, 8'hd0, 8'hd5, 8'b1000_1???, 8'b1010_1???,
         8'b1110_00??, 8'b1111_00??, 8'b1011_01??, 8'b1011_1???,
         8'b1101_1???:
            m = 3'h2;
         default:
            m = 3'h1;
      endcase
      return m;
   endfunction

   // compatibility-mode count in divided clocks
   function automatic logic [CNT_W-1:0] compat_cycles(input logic [7:0] op);
      logic [8:0] prod;
      prod = 9'(machine_cycles(op)) * 9'(MACHINE_CYCLE_CLKS);
      return prod[CNT_W-1:0];
   endfunction

   // fast-mode count in divided clocks
   // fast counts bounded
   function automatic logic [CNT_W-1:0] fast_cycles(input logic [7:0] op,
                                                    input logic [LEN_W-1:0] len);
      logic [CNT_W-1:0] c;
      c = CNT_W'(len);
      casez (op)
         8'h22, 8'h32:
            c = FAST_RETURN;
         8'h83, 8'h93:
            c = FAST_CODE_READ;
         8'he0, 8'hf0:
            c = FAST_EXT_MOVE;
         8'he2, 8'he3, 8'hf2, 8'hf3:
            c = FAST_EXT_MOVE_RI;
         8'ha4:
            c = FAST_MULTIPLY;
         8'h84:
            c = FAST_DIVIDE;
         8'ha3:
            c = FAST_PTR_INC;
         // branches and calls take one extra cycle
         8'h?1, 8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50,
         8'h60, 8'h70, 8'h80, 8'h73, 8'hd5, 8'b1011_01??,
         8'b1011_1???, 8'b1101_1???:
            c = CNT_W'(len) + 6'h1;
         8'h04, 8'h14:
            c = FAST_INDIRECT;
         default:
         begin
            if (len == 3'h1 && op[3:1] == 3'b011 && op[7:4] != 4'hf)
            begin
               c = FAST_INDIRECT;
            end
         end
      endcase
      return c;
   endfunction

   // remaining bytes after the prefix, opcode included
   function automatic logic [LEN_W-1:0] ext_bytes(input logic [7:0] op);
      return (op == 8'h90) ? 3'h3 : 3'h1;
   endfunction

   // prefixed-instruction count per mode
   function automatic logic [CNT_W-1:0] ext_cycles(input logic [7:0] op,
                                                   input logic fast);
      logic [CNT_W-1:0] c;
      unique case (op)
         8'ha4:
            c = FAST_MULT_ACC;
         8'h90:
            c = FAST_PTR_LOAD_ALT;
         8'h93:
            c = FAST_CODE_READ_ALT;
         8'he0, 8'hf0:
            c = FAST_EXT_MOVE_ALT;
         8'ha3:
            c = FAST_PTR_INC_ALT;
         default:
            c = FAST_PREFIX_OTHER;
      endcase
      if (!fast && (op == 8'ha3 || op == 8'he0 || op == 8'hf0))
      begin
         c = COMPAT_PREFIX_LONG;
      end
      return c;
   endfunction

   // close an instruction and arm the next fetch
   function automatic core_state_t finish(input core_state_t s, input logic mode);
      core_state_t r;
      r            = s;
      r.instr_done = 1'b1;
      r.state      = ST_FETCH;
      r.prefixed   = 1'b0;
      r.bytes_got  = '0;
      r.elapsed    = '0;
      r.fast       = mode;
      r.div_ratio  = mode ? FAST_DIV_RATIO : COMPAT_DIV_RATIO;
      return r;
   endfunction

   always_comb
   begin
      next_st            = st;
      next_st.instr_done = 1'b0;
      next_st.cycle_tick = div.tick;
      unique case (st.state)
         ST_START:
         begin
            next_st.fast      = fast_mode;
            next_st.div_ratio = fast_mode ? FAST_DIV_RATIO : COMPAT_DIV_RATIO;
            next_st.state     = ST_FETCH;
         end
         ST_FETCH:
         begin
            // one byte per divided cycle
            // a tick without a byte is a stall, left uncounted
            if (div.tick && code_valid)
            begin
               next_st.elapsed = CNT_W'(st.elapsed + 6'h1);
               if (st.bytes_got == '0)
               begin
                  next_st.opcode = code_byte;
                  if (!st.prefixed && code_byte == PREFIX_OPCODE)
                  begin
                     next_st.prefixed = 1'b1;
                  end
                  else
                  begin
                     next_st.bytes_got = 3'h1;
                     next_st.operands  = '0;
                     if (st.prefixed)
                     begin
                        next_st.bytes_need = ext_bytes(code_byte);
                        next_st.cycles     = ext_cycles(code_byte, st.fast);
                     end
                     else
                     begin
                        next_st.bytes_need = op_bytes(code_byte);
                        next_st.cycles     = st.fast
                                             ? fast_cycles(code_byte, op_bytes(code_byte))
                                             : compat_cycles(code_byte);
                     end
                  end
               end
               else
               begin
                  next_st.operands  = {st.operands[7:0], code_byte};
                  next_st.bytes_got = LEN_W'(st.bytes_got + 3'h1);
               end
               if (next_st.bytes_got != '0 && next_st.bytes_got == next_st.bytes_need)
               begin
                  if (next_st.elapsed >= next_st.cycles)
                  begin
                     next_st = finish(next_st, fast_mode);
                  end
                  else
                  begin
                     next_st.state = ST_EXEC;
                  end
               end
            end
         end
         ST_EXEC:
         begin
            if (div.tick)
            begin
               next_st.elapsed = CNT_W'(st.elapsed + 6'h1);
               if (next_st.elapsed >= st.cycles)
               begin
                  next_st = finish(next_st, fast_mode);
               end
            end
         end
         default:
         begin
            // illegal state code: resequence from start
            next_st.state = ST_START;
         end
      endcase
      next_st.code_req = (next_st.state == ST_FETCH);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st <= CORE_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign div.ratio      = st.div_ratio;
   assign code_req       = st.code_req;
   assign cycle_tick     = st.cycle_tick;
   assign div_ratio      = st.div_ratio;
   assign mode_fast      = st.fast;
   assign instr_done     = st.instr_done;
   assign instr_opcode   = st.opcode;
   assign instr_prefixed = st.prefixed;
   assign instr_operands = st.operands;
   assign instr_bytes    = st.bytes_need;
   assign instr_cycles   = st.cycles;
endmodule

// File: test/cycle_timing_chk.sv
// checker: cycle pacing relations seen at the sequencer ports
`timescale 1ns/1ns
module cycle_timing_chk
   import cycle_timing_pkg::*;
(
   input wire logic             clk,
   input wire logic             reset,
   input wire logic             cycle_tick,
   input wire logic [DIV_W-1:0] div_ratio,
   input wire logic             mode_fast,
   input wire logic             instr_done,
   input wire logic [7:0]       instr_opcode,
   input wire logic [LEN_W-1:0] instr_bytes,
   input wire logic [CNT_W-1:0] instr_cycles
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_fast_run;
      (div_ratio == FAST_DIV_RATIO) [*6];
   endsequence
   sequence s_compat_tick;
      (div_ratio == COMPAT_DIV_RATIO) [*6] ##0 cycle_tick;
   endsequence
   property p_ratio_fast;
      mode_fast |-> div_ratio == FAST_DIV_RATIO;
   endproperty
   a_ratio_fast: assert property (p_ratio_fast)
      else $error("fast ratio wrong");
   property p_ratio_compat;
      !mode_fast |-> div_ratio == COMPAT_DIV_RATIO;
   endproperty
   a_ratio_compat: assert property (p_ratio_compat)
      else $error("compat ratio wrong");
   property p_tick_fast;
      s_fast_run |-> cycle_tick;
   endproperty
   a_tick_fast: assert property (p_tick_fast)
      else $error("fast tick missing");
   property p_tick_compat;
      s_compat_tick |=> !cycle_tick ##1 cycle_tick;
   endproperty
   a_tick_compat: assert property (p_tick_compat)
      else $error("compat tick spacing");
   property p_fast_bound;
      instr_done && mode_fast && instr_opcode != 8'ha4 |-> instr_cycles inside {[1:5]};
   endproperty
   a_fast_bound: assert property (p_fast_bound)
      else $error("fast count out of range");
   property p_fast_plain;
      instr_done && mode_fast && instr_opcode[7:3] inside {5'h05, 5'h07, 5'h13, 5'h01}
         |-> instr_cycles == {3'h0, instr_bytes};
   endproperty
   a_fast_plain: assert property (p_fast_plain)
      else $error("fast count not byte count");
   property p_indirect;
      instr_done && mode_fast && instr_opcode[7:1] inside {7'h13, 7'h1b, 7'h4b, 7'h03}
         |-> instr_cycles == 6'h2;
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect count wrong");
   property p_compat_arith;
      instr_done && !mode_fast && instr_opcode[7:4] inside {4'h0, 4'h2, 4'h3, 4'h9}
         && instr_opcode[3:2] != 2'h0 |-> instr_cycles == MACHINE_CYCLE_CLKS;
   endproperty
   a_compat_arith: assert property (p_compat_arith)
      else $error("compat arithmetic count wrong");
endmodule
bind instruction_cycle_timing cycle_timing_chk chk (.clk(clk), .reset(reset),
   .cycle_tick(cycle_tick), .div_ratio(div_ratio), .mode_fast(mode_fast),
   .instr_done(instr_done), .instr_opcode(instr_opcode), .instr_bytes(instr_bytes),
   .instr_cycles(instr_cycles));

// File: test/prog_mem_model.sv
// model: program memory handing bytes to the sequencer
`timescale 1ns/1ns
module prog_mem_model (
   input  wire logic clk,
   input  wire logic code_req,
   input  wire logic cycle_tick,
   input  wire logic stall,
   output logic      code_valid,
   output logic [7:0] code_byte
);
   logic [7:0] q[$];
   logic       r;
   initial code_valid = 1'b0;
   initial code_byte = 8'h00;
   // byte leaves only after a tick saw it requested
   always @(posedge clk)
   begin
      r = code_req && code_valid;
      #1;
      if (r && cycle_tick && q.size() > 0)
         void'(q.pop_front());
      code_valid = q.size() > 0 && !(stall && $urandom_range(1));
      code_byte = code_valid ? q[0] : ~code_byte;
   end
endmodule

// File: test/testbench.sv
// bench: cycle count scenarios with a result scoreboard
`timescale 1ns/1ns
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %s", $time, m); end end
module testbench;
   import cycle_timing_pkg::*;
   typedef struct {logic [7:0] op; logic [15:0] opr; logic [2:0] nb; logic [5:0] cy; int g;
                   logic pre;} exp_t;
   logic             clk = 1'b0;
   logic             reset = 1'b1;
   logic             fast_mode = 1'b1;
   logic             stall = 1'b0;
   logic             code_valid;
   logic [7:0]       code_byte;
   logic             code_req;
   logic             cycle_tick;
   logic [DIV_W-1:0] div_ratio;
   logic             mode_fast;
   logic             instr_done;
   logic [7:0]       instr_opcode;
   logic             instr_prefixed;
   logic [15:0]      instr_operands;
   logic [LEN_W-1:0] instr_bytes;
   logic [CNT_W-1:0] instr_cycles;
   int               n_fail = 0;
   int               cmp_count = 0;
   int               gap = 0;
   logic             pre_seen = 1'b0;
   exp_t             expq[$];
   exp_t             e;
   logic [7:0]       ar[16] = '{8'h28, 8'h25, 8'h26, 8'h24, 8'h3a, 8'h35, 8'h37, 8'h34,
                                8'h9f, 8'h95, 8'h96, 8'h94, 8'h0c, 8'h05, 8'h06, 8'h04};
   logic [7:0]       fx[9] = '{8'ha4, 8'h84, 8'ha3, 8'h93, 8'he0, 8'h90, 8'h85, 8'h22, 8'ha5};
   always #5 clk = ~clk;
   instruction_cycle_timing uut (.clk(clk), .reset(reset), .fast_mode(fast_mode),
      .code_valid(code_valid), .code_byte(code_byte), .code_req(code_req),
      .cycle_tick(cycle_tick), .div_ratio(div_ratio), .mode_fast(mode_fast),
      .instr_done(instr_done), .instr_opcode(instr_opcode), .instr_prefixed(instr_prefixed),
      .instr_operands(instr_operands), .instr_bytes(instr_bytes), .instr_cycles(instr_cycles));
   prog_mem_model mem (.clk(clk), .code_req(code_req), .cycle_tick(cycle_tick), .stall(stall),
      .code_valid(code_valid), .code_byte(code_byte));
   function automatic void info(input logic [7:0] op, input logic f,
                                output logic [2:0] nb, output logic [5:0] cy);
      nb = op inside {8'h90, 8'h85} ? 3'h3 :
           op inside {8'h25, 8'h24, 8'h35, 8'h34, 8'h95, 8'h94, 8'h05} ? 3'h2 : 3'h1;
      case (op)
         8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h06, 8'h07, 8'h04: cy = f ? 6'h2 : 6'h6;
         8'ha4: cy = f ? 6'h2 : 6'h18;
         8'h84: cy = f ? 6'h4 : 6'h18;
         8'ha3: cy = f ? 6'h2 : 6'h0c;
         8'h93, 8'h90, 8'h85: cy = f ? 6'h3 : 6'h0c;
         8'he0, 8'h22: cy = f ? 6'h4 : 6'h0c;
         default: cy = f ? {3'h0, nb} : 6'h6;
      endcase
   endfunction
   task automatic send(input logic [7:0] op, input logic t);
      exp_t x;
      logic [7:0] b;
      x.opr = 16'h0000;
      x.pre = op == 8'ha5;
      x.op = op == 8'ha5 ? 8'ha4 : op;
      info(x.op, fast_mode, x.nb, x.cy);
      if (op == 8'ha5)
      begin
         mem.q.push_back(op);
         x.cy = 6'h9;
      end
      mem.q.push_back(x.op);
      for (int i = 1; i < x.nb; i++)
      begin
         b = 8'($urandom);
         mem.q.push_back(b);
         x.opr = {x.opr[7:0], b};
      end
      x.g = t ? (fast_mode ? int'(x.cy) : 2 * int'(x.cy)) : 0;
      expq.push_back(x);
   endtask
   task automatic restart(input logic f, input int n);
      reset <= 1'b1;
      fast_mode <= f;
      repeat (n) @(posedge clk);
      #1;
      `CHK(code_req, 1'b0, "request during reset")
      `CHK(div_ratio, COMPAT_DIV_RATIO, "reset ratio")
      @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK(div_ratio, f ? FAST_DIV_RATIO : COMPAT_DIV_RATIO, "mode ratio")
   endtask
   task automatic drain(input string name);
      int k;
      k = 0;
      while (expq.size() > 0 && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      `CHK(expq.size(), 0, "results missing")
      $display("test %s ended", name);
   endtask
   task automatic complete_run();
      $display("compared %0d, failed %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk)
   begin
      gap++;
      pre_seen = !reset && (pre_seen || instr_prefixed === 1'b1);
      if (!reset && instr_done === 1'b1)
      begin
         e = expq.size() > 0 ? expq.pop_front() : exp_t'{8'hxx, 16'hxxxx, 3'hx, 6'hxx, 0, 1'bx};
         `CHK(pre_seen, e.pre, "prefix flag")
         `CHK(instr_opcode, e.op, "opcode")
         `CHK(instr_operands, e.opr, "operands")
         `CHK(instr_bytes, e.nb, "length")
         `CHK(instr_cycles, e.cy, "cycle count")
         if (e.g != 0)
            `CHK(gap, e.g, "completion spacing")
         gap = 0;
         pre_seen = 1'b0;
      end
   end
   initial
   begin
      #300000;
      n_fail++;
      complete_run();
   end
   initial
   begin
      void'($urandom(66));
      restart(1'b1, 19);
      foreach (ar[i])
         send(ar[i], i > 0);
      drain("fast arithmetic");
      foreach (fx[i])
         send(fx[i], i > 0);
      drain("fast fixed counts");
      restart(1'b0, 3);
      foreach (ar[i])
         send(ar[i], i > 0);
      for (int i = 0; i < 7; i++)
         send(fx[i], 1'b1);
      drain("compat counts");
      restart(1'b1, 3);
      stall <= 1'b1;
      repeat (20)
         send(ar[$urandom_range(15)], 1'b0);
      drain("stalled fetch");
      stall <= 1'b0;
      send(8'h84, 1'b0);
      repeat (2) @(posedge clk);
      expq.delete();
      mem.q.delete();
      restart(1'b0, 2);
      send(8'h25, 1'b0);
      drain("reset mid instruction");
      complete_run();
   end
endmodule
